// ===== rtl/crs_pkg.sv
// Package with constants and types for the core register and stack block.
package crs_pkg;
  localparam logic [7:0] ADDR_PTR_FIRST = 8'h80;
  localparam logic [7:0] ADDR_PTR_SECOND = 8'h81;
  localparam logic [7:0] ADDR_SD_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SD_SECOND = 8'h83;
  localparam logic [7:0] ADDR_ACCUM = 8'hff;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;

  // Program counter update source, one-hot.
  typedef enum logic [6:0] {
    CRS_PC_HOLD = 7'h01,
    CRS_PC_INC = 7'h02,
    CRS_PC_JUMP = 7'h04,
    CRS_PC_CALL = 7'h08,
    CRS_PC_REL = 7'h10,
    CRS_PC_IRQ = 7'h20,
    CRS_PC_RET = 7'h40
  } crs_pc_src_t;

  // Flag context, one-hot.
  typedef enum logic [2:0] {
    CRS_CTX_NORMAL = 3'h1,
    CRS_CTX_IRQ = 3'h2,
    CRS_CTX_NMI = 3'h4
  } crs_ctx_t;
endpackage

// ===== rtl/crs_stack.sv
// Six-level hardware return stack of program counter values.
`timescale 1ns/1ps
`default_nettype none
module crs_stack #(
  parameter int DEPTH = crs_pkg::STACK_DEPTH,
  parameter int W = crs_pkg::PC_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_val,
  output logic [W-1:0] top_val,
  output logic [3:0] level
);
  logic [W-1:0] lvl_ff [DEPTH];
  logic [W-1:0] nxt_lvl [DEPTH];
  logic [3:0] level_ff;
  logic [3:0] nxt_level;

  assign top_val = lvl_ff[0];
  assign level = level_ff;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_lvl[i] = lvl_ff[i];
      if (push) begin
        nxt_lvl[i] = (i == 0) ? push_val : lvl_ff[(i == 0) ? 0 : i - 1];
      end else if (pop) begin
        nxt_lvl[i] = (i == DEPTH - 1) ? lvl_ff[i] : lvl_ff[(i == DEPTH - 1) ? i : i + 1];
      end
    end
    nxt_level = level_ff;
    if (push && level_ff != 4'(DEPTH)) begin
      nxt_level = level_ff + 4'h1;
    end else if (pop && !push && level_ff != 4'h0) begin
      nxt_level = level_ff - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        lvl_ff[i] <= crs_pkg::PC_RST;
      end
      level_ff <= 4'h0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        lvl_ff[i] <= nxt_lvl[i];
      end
      level_ff <= nxt_level;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/crs_core_regs.sv
// Programmer-visible core registers, program counter, flags and stack.
// Functional notes
// - Accumulator is eight bits and also data-space location ffh.
// - Pointer registers sit at 80h and 81h in data space.
// - Short-direct registers sit at 82h and 83h in data space.
// - Program counter is twelve bits, covering 4096 bytes.
// - Space beyond 4096 bytes uses a separate bank register.
// - Ordinary instructions advance the counter by one.
// - Counter loads jump, call, relative, vector, reset or pop values.
// - Three carry/zero pairs; only the current context pair is used.
// - Interrupt entry switches pair; interrupt return restores previous.
// - Pairs keep values across switches; only own context reaches them.
// - Carry follows arithmetic carry or borrow; feeds rotate left.
// - Bit test copies tested bit into active carry.
// - Zero flag set when latest result is zero.
// - Reset starts in the non-maskable context.
// - Six twelve-bit stack entries, no visible pointer; the fill count is output on stack_level.
// - Call or interrupt pushes counter, deepest entry lost.
// - Return pops first level into counter, others move up.
// - Over six nestings stack stays deepest, silently.
// - Return on empty stack stays at top, execution continues.
// - Only counter values are stacked, no data registers.
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs #(
  parameter int PC_W = crs_pkg::PC_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] ds_addr,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_hit,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_q,
  output logic [7:0] ptr_first_q,
  output logic [7:0] ptr_second_q,
  input wire logic [6:0] pc_src,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic [PC_W-1:0] pc_rel_sum,
  input wire logic [PC_W-1:0] reset_vector,
  input wire logic irq_enter,
  input wire logic nmi_enter,
  input wire logic return_from_interrupt,
  input wire logic carry_we,
  input wire logic carry_in,
  input wire logic zero_we,
  input wire logic zero_in,
  output logic [PC_W-1:0] prog_counter,
  output logic carry_q,
  output logic zero_q,
  output logic [2:0] ctx_q,
  output logic [3:0] stack_level
);
  logic [7:0] acc_ff, ptr_first_ff, ptr_second_ff, sd_first_ff, sd_second_ff;
  logic [7:0] nxt_acc, nxt_ptr_first, nxt_ptr_second;
  logic [7:0] nxt_sd_first, nxt_sd_second;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [7:0] rdata_ff, nxt_rdata;
  logic hit_ff, nxt_hit;
  logic carry_normal_ctx, zero_normal_ctx, carry_irq_ctx, zero_irq_ctx;
  logic carry_nonmask_ctx, zero_nonmask_ctx;
  logic [2:0] cf_ff, zf_ff, nxt_cf, nxt_zf;
  crs_pkg::crs_ctx_t ctx_ff, nxt_ctx, prev_ff, nxt_prev;
  logic push, pop;
  logic [PC_W-1:0] stack_top;

  // Decodes a data-space address to a one-hot register select.
  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == crs_pkg::ADDR_ACCUM, a == crs_pkg::ADDR_SD_SECOND,
               a == crs_pkg::ADDR_SD_FIRST, a == crs_pkg::ADDR_PTR_SECOND,
               a == crs_pkg::ADDR_PTR_FIRST};
  endfunction

  assign push = pc_src == crs_pkg::CRS_PC_CALL || pc_src == crs_pkg::CRS_PC_IRQ;
  assign pop = pc_src == crs_pkg::CRS_PC_RET;

  crs_stack #(.DEPTH(crs_pkg::STACK_DEPTH), .W(PC_W)) u_stack (
    .ref_clk(ref_clk),
    .srst(srst),
    .push(push),
    .pop(pop),
    .push_val(pc_ff),
    .top_val(stack_top),
    .level(stack_level)
  );

  // Data-space registers; a core write and a bus write to the accumulator
  // in one cycle resolve in favour of the core's own result.
  always_comb begin
    logic [4:0] sel;
    sel = reg_sel(ds_addr);
    nxt_acc = acc_ff;
    nxt_ptr_first = ptr_first_ff;
    nxt_ptr_second = ptr_second_ff;
    nxt_sd_first = sd_first_ff;
    nxt_sd_second = sd_second_ff;
    if (ds_wr && sel[0]) begin
      nxt_ptr_first = ds_wdata;
    end
    if (ds_wr && sel[1]) begin
      nxt_ptr_second = ds_wdata;
    end
    if (ds_wr && sel[2]) begin
      nxt_sd_first = ds_wdata;
    end
    if (ds_wr && sel[3]) begin
      nxt_sd_second = ds_wdata;
    end
    if (ds_wr && sel[4]) begin
      nxt_acc = ds_wdata;
    end
    if (acc_we) begin
      nxt_acc = acc_wdata;
    end
    nxt_hit = |sel;
    case (1'b1)
      sel[0]: nxt_rdata = ptr_first_ff;
      sel[1]: nxt_rdata = ptr_second_ff;
      sel[2]: nxt_rdata = sd_first_ff;
      sel[3]: nxt_rdata = sd_second_ff;
      sel[4]: nxt_rdata = acc_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Program counter; the bank register for wider space lives elsewhere.
  // Twelve-bit counter.
  always_comb begin
    case (pc_src)
      crs_pkg::CRS_PC_INC: nxt_pc = pc_ff + 12'h001;
      crs_pkg::CRS_PC_JUMP: nxt_pc = pc_target;
      crs_pkg::CRS_PC_CALL: nxt_pc = pc_target;
      crs_pkg::CRS_PC_IRQ: nxt_pc = pc_target;
      crs_pkg::CRS_PC_REL: nxt_pc = pc_rel_sum;
      crs_pkg::CRS_PC_RET: nxt_pc = stack_top;
      default: nxt_pc = pc_ff;
    endcase
  end

  // Flag contexts.
  always_comb begin
    nxt_ctx = ctx_ff;
    nxt_prev = prev_ff;
    nxt_cf = cf_ff;
    nxt_zf = zf_ff;
    if (carry_we) begin
      nxt_cf = (cf_ff & ~ctx_ff) | ({3{carry_in}} & ctx_ff);
    end
    if (zero_we) begin
      nxt_zf = (zf_ff & ~ctx_ff) | ({3{zero_in}} & ctx_ff);
    end
    // Switch on entry, restore on return.
    if (nmi_enter) begin
      nxt_prev = ctx_ff;
      nxt_ctx = crs_pkg::CRS_CTX_NMI;
    end else if (irq_enter) begin
      nxt_prev = ctx_ff;
      nxt_ctx = crs_pkg::CRS_CTX_IRQ;
    end else if (return_from_interrupt) begin
      nxt_ctx = prev_ff;
      nxt_prev = crs_pkg::CRS_CTX_NORMAL;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_ff <= crs_pkg::DATA_RST;
      ptr_first_ff <= crs_pkg::DATA_RST;
      ptr_second_ff <= crs_pkg::DATA_RST;
      sd_first_ff <= crs_pkg::DATA_RST;
      sd_second_ff <= crs_pkg::DATA_RST;
      rdata_ff <= crs_pkg::DATA_RST;
      hit_ff <= 1'b0;
      pc_ff <= reset_vector;
      ctx_ff <= crs_pkg::CRS_CTX_NMI;
      prev_ff <= crs_pkg::CRS_CTX_NORMAL;
      cf_ff <= 3'h0;
      zf_ff <= 3'h0;
    end else begin
      acc_ff <= nxt_acc;
      ptr_first_ff <= nxt_ptr_first;
      ptr_second_ff <= nxt_ptr_second;
      sd_first_ff <= nxt_sd_first;
      sd_second_ff <= nxt_sd_second;
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      pc_ff <= nxt_pc;
      ctx_ff <= nxt_ctx;
      prev_ff <= nxt_prev;
      cf_ff <= nxt_cf;
      zf_ff <= nxt_zf;
    end
  end

  assign carry_normal_ctx = cf_ff[0];
  assign zero_normal_ctx = zf_ff[0];
  assign carry_irq_ctx = cf_ff[1];
  assign zero_irq_ctx = zf_ff[1];
  assign carry_nonmask_ctx = cf_ff[2];
  assign zero_nonmask_ctx = zf_ff[2];

  always_comb begin
    case (ctx_ff)
      crs_pkg::CRS_CTX_NORMAL: begin
        carry_q = carry_normal_ctx;
        zero_q = zero_normal_ctx;
      end
      crs_pkg::CRS_CTX_IRQ: begin
        carry_q = carry_irq_ctx;
        zero_q = zero_irq_ctx;
      end
      default: begin
        carry_q = carry_nonmask_ctx;
        zero_q = zero_nonmask_ctx;
      end
    endcase
  end

  assign acc_q = acc_ff;
  assign ptr_first_q = ptr_first_ff;
  assign ptr_second_q = ptr_second_ff;
  assign prog_counter = pc_ff;
  assign ds_rdata = rdata_ff;
  assign ds_hit = hit_ff;
  assign ctx_q = ctx_ff;
  // Bank extension external.
  // The vector loads on every edge while srst is high; the value at the last such edge is kept.
endmodule
`default_nettype wire

// ===== testbench/crs_pm_model.sv
// Program memory model that feeds jump and relative branch targets.
`timescale 1ns/1ps
`default_nettype none
module crs_pm_model (
  input wire logic [11:0] prog_counter,
  input wire logic [7:0] rel_offset,
  output logic [11:0] pc_target,
  output logic [11:0] pc_rel_sum
);
  // Operands vary with the fetch address, so a stale target shows up.
  assign pc_target = prog_counter ^ 12'ha5c;
  assign pc_rel_sum = prog_counter + {{4{rel_offset[7]}}, rel_offset};
endmodule
`default_nettype wire

// ===== testbench/crs_chk_properties.sv
// Checker for the core register and stack block.
`timescale 1ns/1ps
`default_nettype none
module crs_chk #(
  parameter int PC_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [6:0] pc_src,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic nmi_enter,
  input wire logic irq_enter,
  input wire logic [PC_W-1:0] prog_counter,
  input wire logic [2:0] ctx_q,
  input wire logic [3:0] stack_level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence call_s; pc_src == 7'h08; endsequence
  sequence ret_s; pc_src == 7'h40; endsequence
  pc_inc_a: assert property (
    pc_src == 7'h02 |=> prog_counter == $past(prog_counter) + 1'b1)
    else $error("pc did not advance");
  pc_jump_a: assert property (
    pc_src == 7'h04 |=> prog_counter == $past(pc_target))
    else $error("jump target not loaded");
  call_push_a: assert property (
    call_s ##0 stack_level < 4'h6 |=> stack_level == $past(stack_level) + 1'b1)
    else $error("call did not deepen stack");
  stack_full_a: assert property (
    pc_src inside {7'h08, 7'h20} && stack_level == 4'h6 |=> stack_level == 4'h6)
    else $error("full stack level moved");
  call_ret_a: assert property (
    call_s ##1 ret_s |=> prog_counter == $past(prog_counter, 2))
    else $error("return address wrong");
  ret_pop_a: assert property (
    ret_s ##0 stack_level != 4'h0 |=> stack_level == $past(stack_level) - 1'b1)
    else $error("return did not lift stack");
  ret_empty_a: assert property (
    ret_s ##0 stack_level == 4'h0 |=> stack_level == 4'h0)
    else $error("empty stack level moved");
  nmi_ctx_a: assert property (
    nmi_enter |=> ctx_q == 3'h4)
    else $error("nmi context not taken");
  irq_ctx_a: assert property (
    irq_enter && !nmi_enter |=> ctx_q == 3'h2)
    else $error("irq context not taken");
endmodule
bind crs_core_regs crs_chk #(.PC_W(PC_W)) i_chk (.ref_clk, .srst, .pc_src,
  .pc_target, .nmi_enter, .irq_enter, .prog_counter, .ctx_q, .stack_level);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the core register and stack block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] ds_addr = 8'h00, ds_wdata = 8'h00, acc_wdata = 8'h00;
  logic [7:0] rel_off = 8'h00, d, ds_rdata, acc_q;
  logic ds_wr = 1'b0, acc_we = 1'b0, carry_in = 1'b0, zero_in = 1'b0;
  logic nmi_enter = 1'b0, irq_enter = 1'b0, return_from_interrupt = 1'b0;
  logic carry_we = 1'b0, zero_we = 1'b0, ds_hit, carry_q, zero_q;
  logic [6:0] pc_src = 7'h01;
  logic [11:0] pc_target, pc_rel_sum, prog_counter, pc_exp;
  logic [2:0] ctx_q;
  logic [3:0] stack_level;
  logic [7:0] ptr_first_q, ptr_second_q;
  logic [11:0] rst_vec = 12'h5a3;
  logic [11:0] stk[$];
  logic [7:0] adr[6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
  logic [6:0] srcs[4] = '{7'h02, 7'h04, 7'h10, 7'h01};
  int n_fail = 0;
  int comparisons = 0;
  int seed = 32'hd7c3;
  always #5 ref_clk = ~ref_clk;
  crs_core_regs i_dut (.ref_clk, .srst, .ds_addr, .ds_wr, .ds_wdata,
    .ds_rdata, .ds_hit, .acc_we, .acc_wdata, .acc_q, .ptr_first_q,
    .ptr_second_q, .pc_src, .pc_target, .pc_rel_sum,
    .reset_vector(rst_vec), .irq_enter, .nmi_enter, .return_from_interrupt,
    .carry_we, .carry_in, .zero_we, .zero_in, .prog_counter, .carry_q,
    .zero_q, .ctx_q, .stack_level);
  crs_pm_model i_pm (.prog_counter, .rel_offset(rel_off), .pc_target,
    .pc_rel_sum);
  function automatic logic [11:0] nxt_pc(logic [6:0] s, logic [11:0] p);
    if (s == 7'h04) return p ^ 12'ha5c;
    if (s == 7'h10) return p + {{4{rel_off[7]}}, rel_off};
    return (s == 7'h02) ? p + 12'h001 : p;
  endfunction
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic op(logic [6:0] s);
    pc_src = s;
    cyc();
  endtask
  task automatic fl(logic [4:0] v, logic c, logic z);
    {nmi_enter, irq_enter, return_from_interrupt, carry_we, zero_we} = v;
    carry_in = c;
    zero_in = z;
    cyc();
  endtask
  task automatic ckf(logic [2:0] x, logic c, logic z);
    chk("ctx", {9'h0, x}, {9'h0, ctx_q});
    chk("carry", {11'h0, c}, {11'h0, carry_q});
    chk("zero", {11'h0, z}, {11'h0, zero_q});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    ckf(3'h4, 1'b0, 1'b0);
    chk("level", 12'h000, {8'h0, stack_level});
    chk("pc", rst_vec, prog_counter);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      ds_addr = adr[i];
      ds_wdata = d;
      ds_wr = 1'b1;
      cyc();
      ds_wr = 1'b0;
      cyc();
      chk("rdata", {4'h0, i < 5 ? d : 8'h00}, {4'h0, ds_rdata});
      chk("hit", 12'(i < 5), {11'h0, ds_hit});
      if (i == 0) chk("ptr_first", {4'h0, d}, {4'h0, ptr_first_q});
      if (i == 1) chk("ptr_second", {4'h0, d}, {4'h0, ptr_second_q});
    end
    ds_addr = 8'hff;
    ds_wr = 1'b1;
    acc_we = 1'b1;
    acc_wdata = ~d;
    cyc();
    ds_wr = 1'b0;
    acc_we = 1'b0;
    chk("acc", {4'h0, ~d}, {4'h0, acc_q});
    $display("test registers done");
    pc_exp = rst_vec;
    for (int i = 0; i < 16; i++) begin
      rel_off = 8'($random(seed));
      op(srcs[i % 4]);
      pc_exp = nxt_pc(srcs[i % 4], pc_exp);
      chk("pc", pc_exp, prog_counter);
    end
    $display("test counter done");
    for (int i = 0; i < 8; i++) begin
      stk.push_front(pc_exp);
      if (stk.size() > 6) void'(stk.pop_back());
      op(i[0] ? 7'h08 : 7'h20);
      pc_exp = pc_exp ^ 12'ha5c;
      chk("pc", pc_exp, prog_counter);
      chk("level", 12'(stk.size()), {8'h0, stack_level});
    end
    for (int i = 0; i < 7; i++) begin
      op(7'h40);
      if (stk.size() > 0) chk("pc", stk.pop_front(), prog_counter);
      chk("level", 12'(stk.size()), {8'h0, stack_level});
    end
    op(7'h01);
    $display("test stack done");
    fl(5'b00010, 1'b1, 1'b0);
    fl(5'b00100, 1'b0, 1'b0);
    ckf(3'h1, 1'b0, 1'b0);
    fl(5'b00001, 1'b0, 1'b1);
    fl(5'b01000, 1'b0, 1'b0);
    ckf(3'h2, 1'b0, 1'b0);
    fl(5'b00010, 1'b1, 1'b0);
    fl(5'b10000, 1'b0, 1'b0);
    ckf(3'h4, 1'b1, 1'b0);
    fl(5'b00100, 1'b0, 1'b0);
    ckf(3'h2, 1'b1, 1'b0);
    fl(5'b00100, 1'b0, 1'b0);
    fl(5'b00000, 1'b0, 1'b0);
    ckf(3'h1, 1'b0, 1'b1);
    $display("test flags done");
    stop_test();
  end
endmodule
`default_nettype wire
